/* File: rtl/tsh_map.svh */
`ifndef TSH_MAP_SVH
`define TSH_MAP_SVH

// register byte offsets
`define TSH_OFF_CTRL 8'h00
`define TSH_OFF_STAT 8'h04
`define TSH_OFF_DATA 8'h08
`define TSH_OFF_RATE 8'h0C

// control register fields
`define TSH_CTL_FLAG 7
`define TSH_CTL_STA 5
`define TSH_CTL_STO 4
`define TSH_CTL_EN 2
`define TSH_CTL_IE 0

// status codes, prescaler bits masked off
`define TSH_STATUS_MASK 8'hF8
`define TSH_CODE_IDLE 8'hF8
`define TSH_CODE_START 8'h08
`define TSH_CODE_RSTART 8'h10
`define TSH_CODE_AW_ACK 8'h18
`define TSH_CODE_AW_NACK 8'h20
`define TSH_CODE_D_ACK 8'h28
`define TSH_CODE_D_NACK 8'h30
`define TSH_CODE_AR_ACK 8'h40
`define TSH_CODE_AR_NACK 8'h48

// half of the fixed 16-cycle part of one serial clock period
`define TSH_HALF_BASE 16'h0008

// bus responses
`define TSH_RESP_OKAY 2'h0
`define TSH_RESP_SLVERR 2'h2

`endif

/* File: rtl/tsh_pkg.sv */
`default_nettype none

package tsh_pkg;

	typedef enum logic [3:0] {
		S_IDLE, S_WAIT, S_STA_A, S_STA_B, S_HOLD, S_BIT_L, S_BIT_H,
		S_ACK_L, S_ACK_H, S_RS_A, S_RS_B, S_STO_A, S_STO_B, S_STO_C
	} tsh_state_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} tsh_sync_t;

	typedef struct packed {
		tsh_state_t state;
		logic flag;
		logic ie;
		logic en;
		logic sta;
		logic sto;
		logic rs;
		logic rd;
		logic addr_ph;
		logic busy;
		logic [7:0] code;
		logic [7:0] ev;
		logic [1:0] ps;
		logic [7:0] data;
		logic [7:0] sh;
		logic [7:0] br;
		logic [2:0] bitn;
		logic [15:0] cnt;
		logic sda_d;
		logic scl_oe;
		logic sda_oe;
		logic pin_lo;
		logic irq;
		logic awr;
		logic wr;
		logic have_aw;
		logic have_w;
		logic [7:0] awa;
		logic [7:0] wd;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic arr;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tsh_st_t;

endpackage : tsh_pkg

`default_nettype wire

/* File: rtl/tsh_sync.sv */
`default_nettype none

module tsh_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] din,
	output logic [1:0] dout
);
	tsh_pkg::tsh_sync_t r_reg;
	tsh_pkg::tsh_sync_t r_next;

	// second stage is the only reader of the first
	always_comb begin
		r_next = r_reg;
		r_next.s1 = din;
		r_next.s2 = r_reg.s1;
	end

	// reset to released lines so no false start is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign dout = r_reg.s2;

endmodule : tsh_sync

`default_nettype wire

/* File: rtl/tsh_top.sv */
// Function
// [R1] interrupt out only when flag, interface enable and global enable all set
// [R2] with interrupt disabled software polls the flag
// [R3] flag set after every bus event
// [R4] while flag set, status holds a bus code and block waits
// [R5] writing one to flag bit clears the flag
// [R6] no bus operation starts while the flag stays set
// [R7] clear with start request begins a START at once
// [R8] after START, flag set and start-sent code posted
// [R9] software loads address with direction into data register first
// [R10] after address or data byte, flag set, code shows acknowledge
// [R11] clearing flag after data load sends that byte, then flags again
// [R12] after a requested STOP the flag stays clear
// [R13] clock line held low while the flag is set
// [R14] software updates registers, then control write picks the operation
// [R15] software masks status with F8 before comparing
// [R16] software checks status each step, branches on mismatch
// [R17] status code updated the cycle after the flag rises
// [R18] flag clear means status shows the no-information code
// [R19] start waits until the bus is free
// [R20] masked code after START equals 08
// [R21] writing zero to flag bit changes nothing and starts nothing; code still stores IE and EN from such a write
`include "tsh_map.svh"
`default_nettype none

module tsh_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpu_gie,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq
);
	tsh_pkg::tsh_st_t r_reg;
	tsh_pkg::tsh_st_t r_next;
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic [15:0] half_len;
	logic tick;
	logic wr_do;
	logic ctl_wr;
	logic op_go;
	logic setf;
	logic [7:0] evc;
	logic ack;
	logic map_ok;

	// all checks below run on the one bus clock
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// both bus lines come from outside the clock domain
	tsh_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({scl_i, sda_i}),
		.dout(pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	always_comb begin
		r_next = r_reg;
		setf = 1'b0;
		evc = `TSH_CODE_IDLE;
		ack = !sda_s;
		// half period in cycles: 8 + rate * 4^prescale
		half_len = `TSH_HALF_BASE + 16'(16'(r_reg.br) * (16'h0001 << {r_reg.ps, 1'b0}));
		tick = (r_reg.cnt <= 16'h0001);
		if (!tick) begin
			r_next.cnt = r_reg.cnt - 16'h0001;
		end

		// write address and data taken in either order
		if (r_reg.awr && s_axi_awvalid) begin
			r_next.have_aw = 1'b1;
			r_next.awa = s_axi_awaddr;
		end
		if (r_reg.wr && s_axi_wvalid) begin
			r_next.have_w = 1'b1;
			r_next.wd = s_axi_wdata[7:0];
			r_next.wstb = s_axi_wstrb[0];
		end
		wr_do = r_reg.have_aw && r_reg.have_w && !r_reg.bvalid;
		map_ok = (r_reg.awa == `TSH_OFF_CTRL) || (r_reg.awa == `TSH_OFF_STAT) ||
			(r_reg.awa == `TSH_OFF_DATA) || (r_reg.awa == `TSH_OFF_RATE);
		ctl_wr = wr_do && r_reg.wstb && (r_reg.awa == `TSH_OFF_CTRL);
		// [R5] one in flag bit clears and launches
		op_go = ctl_wr && r_reg.wd[`TSH_CTL_FLAG];
		if (wr_do) begin
			r_next.have_aw = 1'b0;
			r_next.have_w = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = map_ok ? `TSH_RESP_OKAY : `TSH_RESP_SLVERR;
			if (r_reg.wstb && r_reg.awa == `TSH_OFF_DATA) begin
				r_next.data = r_reg.wd;
			end
			if (r_reg.wstb && r_reg.awa == `TSH_OFF_RATE) begin
				r_next.br = r_reg.wd;
			end
			if (r_reg.wstb && r_reg.awa == `TSH_OFF_STAT) begin
				r_next.ps = r_reg.wd[1:0];
			end
		end
		// [R21] enables always stored, operation bits only with flag one
		if (ctl_wr) begin
			r_next.ie = r_reg.wd[`TSH_CTL_IE];
			r_next.en = r_reg.wd[`TSH_CTL_EN];
		end
		// [R14] control write picks the next operation
		if (op_go) begin
			r_next.flag = 1'b0;
			r_next.sta = r_reg.wd[`TSH_CTL_STA];
			r_next.sto = r_reg.wd[`TSH_CTL_STO];
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end

		// reads answer one cycle after the address is taken
		if (r_reg.arr && s_axi_arvalid) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = `TSH_RESP_OKAY;
			case (s_axi_araddr)
				`TSH_OFF_CTRL: r_next.rdata = {24'h000000, r_reg.flag, 1'b0, r_reg.sta,
					r_reg.sto, 1'b0, r_reg.en, 1'b0, r_reg.ie};
				// [R4] status shows the bus code plus prescaler
				`TSH_OFF_STAT: r_next.rdata = {24'h000000, r_reg.code[7:3], 1'b0, r_reg.ps};
				`TSH_OFF_DATA: r_next.rdata = {24'h000000, r_reg.data};
				`TSH_OFF_RATE: r_next.rdata = {24'h000000, r_reg.br};
				default: begin
					r_next.rdata = 32'h00000000;
					r_next.rresp = `TSH_RESP_SLVERR;
				end
			endcase
		end else if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end

		// [R19] track bus busy from observed start and stop
		r_next.sda_d = sda_s;
		if (scl_s && r_reg.sda_d && !sda_s) begin
			r_next.busy = 1'b1;
		end else if (scl_s && !r_reg.sda_d && sda_s) begin
			r_next.busy = 1'b0;
		end

		case (r_reg.state)
			tsh_pkg::S_IDLE: begin
				// [R7] start request begins at once
				if (op_go && r_reg.wd[`TSH_CTL_STA]) begin
					r_next.state = tsh_pkg::S_WAIT;
					r_next.rs = 1'b0;
				end
			end
			tsh_pkg::S_WAIT: begin
				// [R19] start only once the bus is free
				if (!r_reg.busy && scl_s && sda_s) begin
					r_next.state = tsh_pkg::S_STA_A;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_STA_A: begin
				if (tick) begin
					r_next.state = tsh_pkg::S_STA_B;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_STA_B: begin
				// [R8] start sent, flag and code
				if (tick) begin
					setf = 1'b1;
					// [R20] plain start posts 08
					evc = r_reg.rs ? `TSH_CODE_RSTART : `TSH_CODE_START;
					r_next.addr_ph = 1'b1;
					r_next.sta = 1'b0;
					r_next.state = tsh_pkg::S_HOLD;
				end
			end
			tsh_pkg::S_HOLD: begin
				// [R6] leave only on a clearing control write or when the block is disabled
				if (op_go) begin
					if (r_reg.wd[`TSH_CTL_STO]) begin
						r_next.state = tsh_pkg::S_STO_A;
					end else if (r_reg.wd[`TSH_CTL_STA]) begin
						r_next.state = tsh_pkg::S_RS_A;
						r_next.rs = 1'b1;
					end else begin
						// [R11] send the byte now in the data register
						r_next.state = tsh_pkg::S_BIT_L;
						r_next.sh = r_reg.data;
						r_next.rd = r_reg.data[0];
						r_next.bitn = 3'h7;
					end
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_BIT_L: begin
				if (tick) begin
					r_next.state = tsh_pkg::S_BIT_H;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_BIT_H: begin
				// a slave holding the clock low stretches the high half
				if (!scl_s) begin
					r_next.cnt = r_reg.cnt;
				end else if (tick) begin
					r_next.cnt = half_len;
					if (r_reg.bitn == 3'h0) begin
						r_next.state = tsh_pkg::S_ACK_L;
					end else begin
						r_next.state = tsh_pkg::S_BIT_L;
						r_next.bitn = r_reg.bitn - 3'h1;
						r_next.sh = {r_reg.sh[6:0], 1'b0};
					end
				end
			end
			tsh_pkg::S_ACK_L: begin
				if (tick) begin
					r_next.state = tsh_pkg::S_ACK_H;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_ACK_H: begin
				if (!scl_s) begin
					r_next.cnt = r_reg.cnt;
				end else if (tick) begin
					// [R10] code carries the acknowledge seen
					setf = 1'b1;
					if (!r_reg.addr_ph) begin
						evc = ack ? `TSH_CODE_D_ACK : `TSH_CODE_D_NACK;
					end else if (r_reg.rd) begin
						evc = ack ? `TSH_CODE_AR_ACK : `TSH_CODE_AR_NACK;
					end else begin
						evc = ack ? `TSH_CODE_AW_ACK : `TSH_CODE_AW_NACK;
					end
					r_next.addr_ph = 1'b0;
					r_next.state = tsh_pkg::S_HOLD;
				end
			end
			tsh_pkg::S_RS_A: begin
				if (tick) begin
					r_next.state = tsh_pkg::S_RS_B;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_RS_B: begin
				if (!scl_s) begin
					r_next.cnt = r_reg.cnt;
				end else if (tick) begin
					r_next.state = tsh_pkg::S_STA_A;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_STO_A: begin
				if (tick) begin
					r_next.state = tsh_pkg::S_STO_B;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_STO_B: begin
				if (!scl_s) begin
					r_next.cnt = r_reg.cnt;
				end else if (tick) begin
					r_next.state = tsh_pkg::S_STO_C;
					r_next.cnt = half_len;
				end
			end
			tsh_pkg::S_STO_C: begin
				// [R12] stop done, flag left clear
				if (tick) begin
					r_next.sto = 1'b0;
					r_next.rs = 1'b0;
					r_next.state = r_reg.sta ? tsh_pkg::S_WAIT : tsh_pkg::S_IDLE;
				end
			end
			default: r_next.state = tsh_pkg::S_IDLE;
		endcase

		// [R3] hardware set wins over a clear in the same cycle
		if (setf) begin
			r_next.flag = 1'b1;
			r_next.ev = evc;
		end
		// disabling abandons any transfer; the enable being written counts, so one
		// control write can both enable the block and request a start
		if (!r_next.en) begin
			r_next.state = tsh_pkg::S_IDLE;
		end

		// [R17] [R18] code lags flag, idle otherwise
		r_next.code = r_reg.flag ? r_reg.ev : `TSH_CODE_IDLE;
		// [R1] interrupt gated by both enables
		r_next.irq = r_reg.flag && r_reg.ie && cpu_gie;

		// [R13] clock low while the flag is set
		case (r_next.state)
			tsh_pkg::S_STA_B, tsh_pkg::S_HOLD, tsh_pkg::S_BIT_L, tsh_pkg::S_ACK_L,
			tsh_pkg::S_RS_A, tsh_pkg::S_STO_A: r_next.scl_oe = 1'b1;
			default: r_next.scl_oe = r_next.flag;
		endcase
		case (r_next.state)
			tsh_pkg::S_STA_A, tsh_pkg::S_STA_B, tsh_pkg::S_STO_A,
			tsh_pkg::S_STO_B: r_next.sda_oe = 1'b1;
			tsh_pkg::S_BIT_L, tsh_pkg::S_BIT_H: r_next.sda_oe = !r_next.sh[7];
			tsh_pkg::S_HOLD: r_next.sda_oe = r_reg.sda_oe;
			default: r_next.sda_oe = 1'b0;
		endcase
		r_next.pin_lo = 1'b0;

		// channel readies follow the held state
		r_next.awr = !r_next.have_aw && !r_next.bvalid;
		r_next.wr = !r_next.have_w && !r_next.bvalid;
		r_next.arr = !r_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
			r_reg.code <= `TSH_CODE_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// every output is a field of the state register
	assign s_axi_awready = r_reg.awr;
	assign s_axi_wready = r_reg.wr;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = r_reg.arr;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign scl_o = r_reg.pin_lo;
	assign sda_o = r_reg.pin_lo;
	assign scl_oe = r_reg.scl_oe;
	assign sda_oe = r_reg.sda_oe;
	assign irq = r_reg.irq;

	a_irq_gating: assert property ( // [R1]
		##1 irq == $past(r_reg.flag && r_reg.ie && cpu_gie)
	) else $error("interrupt not gated by flag and enables");

	a_flag_clear: assert property ( // [R5]
		op_go && !setf |=> !r_reg.flag
	) else $error("flag not cleared by writing one");

	a_zero_keeps: assert property ( // [R21]
		ctl_wr && !r_reg.wd[`TSH_CTL_FLAG] && r_reg.flag |=> r_reg.flag
	) else $error("writing zero changed the flag");

	a_hold_still: assert property ( // [R6]
		r_reg.flag && !op_go && r_next.en |=> r_reg.state == tsh_pkg::S_HOLD
	) else $error("bus moved while flag set");

	a_clock_stretch: assert property ( // [R13]
		r_reg.flag |-> scl_oe
	) else $error("clock released while flag set");

	a_code_lag: assert property ( // [R17]
		$rose(r_reg.flag) |-> r_reg.code == `TSH_CODE_IDLE ##1 r_reg.code == r_reg.ev
	) else $error("status not updated the cycle after flag");

	a_idle_code: assert property ( // [R18]
		!r_reg.flag && !$past(r_reg.flag) |-> r_reg.code == `TSH_CODE_IDLE
	) else $error("status not idle code while flag clear");

	a_start_code: assert property ( // [R20]
		$past(r_reg.state) == tsh_pkg::S_STA_B && $rose(r_reg.flag) && !r_reg.rs
		|=> (r_reg.code & `TSH_STATUS_MASK) == `TSH_CODE_START
	) else $error("start code not 08");

	a_stop_noflag: assert property ( // [R12]
		r_reg.state == tsh_pkg::S_STO_C && tick && r_reg.en |=> !r_reg.flag
	) else $error("flag set after stop");

	a_start_go: assert property ( // [R7]
		r_reg.state == tsh_pkg::S_IDLE && op_go && r_reg.wd[`TSH_CTL_STA] && r_reg.wd[`TSH_CTL_EN]
		|=> r_reg.state == tsh_pkg::S_WAIT
	) else $error("start request not taken at once");

endmodule : tsh_top

`default_nettype wire

/* File: tb/tsh_slave.sv */
`default_nettype none

// behavioural bus target: samples bytes msb first and answers with an ack
module tsh_slave (
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_en,
	output logic sda_oe,
	output logic [7:0] last_byte,
	output logic saw_stop
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] bitc;
	logic [7:0] sh;

	initial begin
		sda_oe = 1'h0;
		bitc = 4'h0;
		sh = 8'h00;
		last_byte = 8'h00;
		saw_stop = 1'h0;
	end
	// start and stop are data edges while the clock line is high; the clock is
	// looked at a little later, since data may move in the step that the clock falls
	always @(negedge sda) begin
		#1;
		if (scl) begin
			bitc = 4'h0;
			saw_stop = 1'h0;
		end
	end
	always @(posedge sda) begin
		#1;
		if (scl) saw_stop = 1'h1;
	end
	// bits 1..8 shift in, the ninth rising edge is the ack slot
	always @(posedge scl) begin
		if (bitc < 4'h8) sh = {sh[6:0], sda};
		if (bitc < 4'h9) bitc = bitc + 4'h1;
	end
	// ack is driven only in the low phase so it never looks like a stop
	always @(negedge scl) begin
		if (bitc == 4'h8 && !sda_oe) begin
			last_byte = sh;
			sda_oe = ack_en;
		end else if (bitc == 4'h9) begin
			sda_oe = 1'h0;
			bitc = 4'h0;
		end
	end
endmodule : tsh_slave

`default_nettype wire

/* File: tb/tsh_top_test.sv */
`include "tsh_map.svh"
`default_nettype none

module tsh_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic cpu_gie, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, irq;
	logic sl_oe, ack_en, busy_lo, sl_stop;
	logic [7:0] sl_byte;
	int fail_count, cmp_count, cyc;
	logic [7:0] bytes [3] = '{8'hA0, 8'h5A, 8'h33};
	logic [7:0] codes [3] = '{8'h18, 8'h28, 8'h30};
	logic acks [3] = '{1'h1, 1'h1, 1'h0};

	tsh_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .cpu_gie(cpu_gie), .scl_i(scl_i), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	tsh_slave u_slave (.scl(scl_i), .sda(sda_i), .ack_en(ack_en), .sda_oe(sl_oe),
		.last_byte(sl_byte), .saw_stop(sl_stop));

	// pulled-up open-drain lines; busy_lo plays a foreign master
	assign scl_i = !scl_oe;
	assign sda_i = !(sda_oe || sl_oe || busy_lo);

	initial begin
		aclk = 1'h0;
		forever #2 aclk = !aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'h0;
		w = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w && s_axi_wready) begin
				w = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_rd

	// software polls the flag since the interrupt may be off
	task automatic wait_flag();
		do axi_rd(`TSH_OFF_CTRL); while (!rd[7]);
	endtask : wait_flag

	// hang guard, well above the few thousand cycles the sequence needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		{cpu_gie, busy_lo} = 2'h0;
		ack_en = 1'h1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		axi_rd(`TSH_OFF_STAT);
		chk(rd, 32'h000000F8);
		chk(32'(rs), 32'(`TSH_RESP_OKAY));
		axi_rd(8'h10);
		chk(32'(rs), 32'(`TSH_RESP_SLVERR));
		axi_wr(8'h14, 32'h000000FF);
		chk(32'(rs), 32'(`TSH_RESP_SLVERR));
		// prescaler 1 and rate 3: half period 8 + 3*4 = 20 cycles, a 160 ns serial clock
		axi_wr(`TSH_OFF_STAT, 32'h00000001);
		axi_wr(`TSH_OFF_RATE, 32'h00000003);
		chk(32'(rs), 32'(`TSH_RESP_OKAY));
		axi_wr(`TSH_OFF_CTRL, 32'h00000025);
		repeat (100) @(posedge aclk);
		chk({scl_oe, sda_oe}, 32'h0);
		// foreign master holds the bus: start must wait for its stop
		busy_lo <= 1'h1;
		axi_wr(`TSH_OFF_CTRL, 32'h000000A5);
		repeat (150) @(posedge aclk);
		chk({scl_oe, sda_oe}, 32'h0);
		busy_lo <= 1'h0;
		wait_flag();
		axi_rd(`TSH_OFF_STAT);
		chk(rd & 32'hF8, 32'h08);
		chk({scl_o, sda_o, scl_oe}, 32'h1);
		chk(irq, 1'h0);
		cpu_gie <= 1'h1;
		repeat (3) @(posedge aclk);
		chk(irq, 1'h1);
		repeat (200) @(posedge aclk);
		chk(scl_oe, 1'h1);
		axi_wr(`TSH_OFF_CTRL, 32'h00000005);
		repeat (100) @(posedge aclk);
		axi_rd(`TSH_OFF_CTRL);
		chk({scl_oe, rd[7]}, 2'h3);
		// address, data with ack, data with nack
		for (int i = 0; i < 3; i++) begin
			ack_en <= acks[i];
			axi_wr(`TSH_OFF_DATA, 32'(bytes[i]));
			axi_wr(`TSH_OFF_CTRL, 32'h00000085);
			axi_rd(`TSH_OFF_CTRL);
			chk({irq, rd[7]}, 2'h0);
			wait_flag();
			axi_rd(`TSH_OFF_STAT);
			chk(rd & 32'hF8, 32'(codes[i]));
			chk(sl_byte, bytes[i]);
		end
		ack_en <= 1'h1;
		axi_wr(`TSH_OFF_CTRL, 32'h00000095);
		repeat (300) @(posedge aclk);
		axi_rd(`TSH_OFF_CTRL);
		chk({sl_stop, scl_oe, sda_oe, rd[7]}, 4'h8);
		// prescaler bits stay in the low bits beside the idle code
		axi_rd(`TSH_OFF_STAT);
		chk(rd, 32'h000000F9);
		tally_and_finish();
	end
endmodule : tsh_top_test

`default_nettype wire
